// ---- sim/lcsc_machine_model.sv ----
// Behavioural guarded machine: contactors with feedback and start gating
`timescale 1ns/100ps
module lcsc_machine_model (
  input  wire mclk_i,
  input  wire rst_i,
  input  wire out_a_i,
  input  wire out_b_i,
  input  wire start_i,
  input  wire slow_i,
  input  wire stuck_i,
  output wire fb1_o,
  output wire fb2_o,
  output wire motion_o
);
  // ======
  // Contactor coils follow the outputs promptly or slowly
  reg  [7:0] coil_a_reg;
  reg  [7:0] coil_b_reg;
  wire       pulled_a = slow_i ? coil_a_reg[5] : coil_a_reg[0];
  wire       pulled_b = slow_i ? coil_b_reg[5] : coil_b_reg[0];
  always @(posedge mclk_i) begin
    if (rst_i) begin
      coil_a_reg <= 8'h00;
      coil_b_reg <= 8'h00;
    end else begin
      coil_a_reg <= {coil_a_reg[6:0], out_a_i};
      coil_b_reg <= {coil_b_reg[6:0], out_b_i};
    end
  end
  // A contactor that fails to pull in keeps reporting released
  assign fb1_o    = stuck_i | ~pulled_a;
  assign fb2_o    = stuck_i | ~pulled_b;
  // Motion needs a deliberate start besides the curtain outputs
  assign motion_o = start_i & pulled_a & pulled_b;
endmodule // lcsc_machine_model

// ---- sim/lcsc_top_assertions.sv ----
// Port-level assertions for the light curtain controller
`timescale 1ns/100ps
module lcsc_checker #(
  parameter integer NB = 20
) (
  input wire          mclk_i,
  input wire          rst_i,
  input wire [NB-1:0] beam_hit_i,
  input wire          test_closed_i,
  input wire          reset_sw_i,
  input wire          selfchk_fault_i,
  input wire          emit_on_o,
  input wire          safety_switch_outputs_a_o,
  input wire          safety_switch_outputs_b_o,
  input wire          aux_o,
  input wire          status_red_o,
  input wire          reset_yel_o,
  input wire [11:0]   disp_o
);
  // ======
  // Helpers
  // Lockout may end a few cycles after release, so count quiet cycles first
  reg  [3:0] quiet_reg;
  wire       lock = disp_o[11:8] == 4'he;
  wire       on_a = safety_switch_outputs_a_o;
  wire       on_b = safety_switch_outputs_b_o;
  always @(posedge mclk_i) begin
    if (rst_i || reset_sw_i) begin
      quiet_reg <= 4'h0;
    end else if (quiet_reg != 4'hf) begin
      quiet_reg <= quiet_reg + 4'h1;
    end
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // ======
  // Assertions
  a_fault_stop: assert property ($rose(selfchk_fault_i) |-> ##[1:8] (lock && !on_a))
    else $error("self check fault not locked out");
  a_chan_agree: assert property (on_a == on_b)
    else $error("safety output channels disagree");
  a_lock_stays: assert property (lock && quiet_reg > 4'h8 |=> lock)
    else $error("lockout left without reset");
  a_lock_off: assert property (lock && $past(lock) |-> !on_a && !on_b)
    else $error("outputs on during lockout");
  a_sync_trip: assert property (!beam_hit_i[0] |-> ##[1:7] !on_a)
    else $error("sync beam block did not trip");
  a_test_dark: assert property (!test_closed_i |-> ##[1:4] !emit_on_o)
    else $error("emission kept with test open");
  a_aux_follow: assert property (aux_o |-> on_a)
    else $error("aux on with outputs off");
  a_on_not_red: assert property (on_a |-> !status_red_o)
    else $error("red status with outputs on");
  a_run_yellow: assert property (on_a |-> reset_yel_o)
    else $error("yellow not steady in run");
  c_run: cover property ($rose(on_a));
  c_lock: cover property ($rose(lock));
  c_aux: cover property (aux_o && on_a);
endmodule // lcsc_checker

bind lcsc_top lcsc_checker #(.NB(NB)) lcsc_checker_i (
  .mclk_i(mclk_i), .rst_i(rst_i), .beam_hit_i(beam_hit_i), .test_closed_i(test_closed_i),
  .reset_sw_i(reset_sw_i), .selfchk_fault_i(selfchk_fault_i), .emit_on_o(emit_on_o),
  .safety_switch_outputs_a_o(safety_switch_outputs_a_o),
  .safety_switch_outputs_b_o(safety_switch_outputs_b_o), .aux_o(aux_o),
  .status_red_o(status_red_o), .reset_yel_o(reset_yel_o), .disp_o(disp_o));

// ---- sim/lcsc_top_test.sv ----
// Self-checking bench for the light curtain safety controller
`timescale 1ns/100ps
module lcsc_top_test;
  localparam integer      NB = 20;
  localparam integer      ZB = 5;
  localparam [NB-1:0]     ALL = {NB{1'b1}}, ONE = 1, RUN2 = 3, RUN3 = 7;
  reg                     mclk_i = 1'b0, rst_i = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  reg  [7:0]              paddr = 8'h00;
  reg  [31:0]             pwdata = 32'h0, rd;
  reg  [NB-1:0]           beam = {NB{1'b1}};
  reg                     code = 1'b0, tclosed = 1'b1, rsw = 1'b0, selft = 1'b0;
  reg                     stuck = 1'b0, slow = 1'b0, er;
  wire [31:0]             prdata;
  wire                    pready, pslverr, emit_on, out_a, out_b, aux, grn, red, yel, fb1, fb2;
  wire                    egrn, ered;
  wire [3:0]              zgrn, zred, edig;
  wire [11:0]             disp;
  integer                 error_cnt = 0, comparisons = 0, seed = 26, b, k;

  lcsc_top #(.RST_MIN_CYC(20), .RST_MAX_CYC(100), .FB_CYC(10), .BLINK_CYC(4)) lcsc_top_i (
    .mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .beam_hit_i(beam), .rx_code_i(code), .test_closed_i(tclosed),
    .reset_sw_i(rsw), .fb1_i(fb1), .fb2_i(fb2), .selfchk_fault_i(selft), .emit_on_o(emit_on),
    .safety_switch_outputs_a_o(out_a), .safety_switch_outputs_b_o(out_b), .aux_o(aux),
    .status_grn_o(grn), .status_red_o(red), .reset_yel_o(yel), .zone_grn_o(zgrn),
    .zone_red_o(zred), .disp_o(disp), .emit_grn_o(egrn), .emit_red_o(ered), .emit_digit_o(edig));
  lcsc_machine_model lcsc_machine_model_i (
    .mclk_i(mclk_i), .rst_i(rst_i), .out_a_i(out_a), .out_b_i(out_b), .start_i(1'b0),
    .slow_i(slow), .stuck_i(stuck), .fb1_o(fb1), .fb2_o(fb2), .motion_o());

  // ======
  // Helpers
  task chk(input [31:0] got, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("unexpected at %0t: saw %h, expected %h", $time, got, exp);
      end
    end
  endtask
  task wrap_up;
    begin
      if (error_cnt == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
    end
  endtask
  // Bus cycle: request held until pready is seen high at a rising edge; a hang is the watchdog's
  task apb(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge mclk_i);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk_i);
      pen <= 1'b1;
      @(posedge mclk_i);
      while (pready !== 1'b1) begin
        @(posedge mclk_i);
      end
      chk(pready, 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
    end
  endtask
  task wait_out(input e, input integer m);
    integer n;
    begin
      n = 0;
      @(negedge mclk_i);
      while (out_a !== e && n < m) begin
        @(negedge mclk_i);
        n = n + 1;
      end
      chk(out_a, e);
    end
  endtask
  task hold(input e, input integer m);
    integer n, bad;
    begin
      bad = 0;
      for (n = 0; n < m; n = n + 1) begin
        @(negedge mclk_i);
        if (out_a !== e) bad = 1;
      end
      chk(bad, 0);
    end
  endtask
  task flash(input [1:0] s);
    integer n, ones;
    begin
      ones = 0;
      for (n = 0; n < 12; n = n + 1) begin
        @(negedge mclk_i);
        ones = ones + (s == 2'd0 ? grn : s == 2'd1 ? red : s == 2'd2 ? yel : zgrn[0]);
      end
      chk(ones > 0 && ones < 12, 1'b1);
    end
  endtask
  task press(input integer len);
    begin
      @(posedge mclk_i);
      rsw <= 1'b1;
      repeat (len) @(posedge mclk_i);
      rsw <= 1'b0;
    end
  endtask
  task put(input [NB-1:0] v);
    begin
      @(posedge mclk_i);
      beam <= v;
    end
  endtask
  function [11:0] lk(input [3:0] f);
    lk = {4'he, 4'h0, f};
  endfunction
  function [3:0] zone(input integer bb);
    zone = 4'h1 << (bb / ZB);
  endfunction

  // ======
  // Stimulus
  initial begin
    forever #2.5 mclk_i = ~mclk_i;
  end
  initial begin
    repeat (20000) @(posedge mclk_i);
    chk(1'b0, 1'b1);
    wrap_up;
  end
  initial begin
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk(er, 1'b1);
    wait_out(1'b1, 60);
    chk({yel, red, disp}, {1'b1, 1'b0, 12'h0});
    chk({out_b, egrn, ered}, 3'b110);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h5);
    for (b = 0; b < 4; b = b + 1) begin
      k = 1 + {$random(seed)} % (NB - 1);
      put(ALL ^ (ONE << k));
      wait_out(1'b0, 10);
      chk({disp, zred, zgrn}, {12'h1, zone(k), ~zone(k)});
      put(ALL);
      wait_out(1'b1, 10);
    end
    apb(1'b1, 8'h04, 32'h1);
    flash(2'd3);
    apb(1'b1, 8'h00, 32'h8);
    flash(2'd0);
    k = 1 + {$random(seed)} % (NB - 2);
    put(ALL ^ (RUN2 << k));
    hold(1'b1, 12);
    k = 1 + {$random(seed)} % (NB - 3);
    put(ALL ^ (RUN3 << k));
    wait_out(1'b0, 10);
    put(ALL);
    wait_out(1'b1, 10);
    put(ALL ^ ONE);
    wait_out(1'b0, 10);
    put(ALL);
    wait_out(1'b1, 10);
    apb(1'b1, 8'h00, 32'h0);
    @(posedge mclk_i);
    code <= 1'b1;
    wait_out(1'b0, 10);
    apb(1'b1, 8'h00, 32'h10);
    wait_out(1'b1, 20);
    apb(1'b1, 8'h00, 32'h0);
    wait_out(1'b0, 10);
    @(posedge mclk_i);
    code <= 1'b0;
    wait_out(1'b1, 20);
    @(posedge mclk_i);
    tclosed <= 1'b0;
    wait_out(1'b0, 10);
    chk(emit_on, 1'b0);
    @(posedge mclk_i);
    tclosed <= 1'b1;
    slow <= 1'b1;
    wait_out(1'b1, 20);
    apb(1'b1, 8'h00, 32'h2);
    hold(1'b1, 4);
    chk(aux, 1'b1);
    put(ALL ^ (ONE << 7));
    wait_out(1'b0, 10);
    chk(aux, 1'b0);
    put(ALL);
    wait_out(1'b1, 10);
    apb(1'b1, 8'h00, 32'h0);
    hold(1'b1, 4);
    chk(aux, 1'b0);
    apb(1'b1, 8'h00, 32'h4);
    hold(1'b1, 20);
    @(posedge mclk_i);
    stuck <= 1'b1;
    wait_out(1'b0, 30);
    @(negedge mclk_i);
    chk(disp, lk(4'h2));
    flash(2'd1);
    @(posedge mclk_i);
    stuck <= 1'b0;
    apb(1'b1, 8'h00, 32'h0);
    hold(1'b0, 30);
    press(40);
    wait_out(1'b1, 80);
    @(posedge mclk_i);
    selft <= 1'b1;
    wait_out(1'b0, 10);
    @(negedge mclk_i);
    chk({disp, edig}, {lk(4'h3), 4'h3});
    press(40);
    hold(1'b0, 30);
    @(posedge mclk_i);
    selft <= 1'b0;
    press(40);
    wait_out(1'b1, 80);
    apb(1'b1, 8'h00, 32'h1);
    put(ALL ^ (ONE << 3));
    wait_out(1'b0, 10);
    put(ALL);
    hold(1'b0, 20);
    flash(2'd2);
    press(5);
    hold(1'b0, 20);
    press(120);
    hold(1'b0, 20);
    press(40);
    wait_out(1'b1, 20);
    chk(yel, 1'b1);
    wrap_up;
  end
endmodule // lcsc_top_test

// ---- verilog/lcsc_chan.v ----
// One redundant beam evaluation channel: clear decision and blocked beam count
`timescale 1ns/100ps
module lcsc_chan #(
  parameter integer NB = 20,
  parameter integer CW = 8
) (
  input  wire          mclk_i,
  input  wire          rst_i,
  input  wire [NB-1:0] hit_i,
  input  wire          rres_i,
  output reg           clear_o,
  output reg  [CW-1:0] blocked_o
);

  // ==========================================
  // Blocked beam count
  function [CW-1:0] popcnt;
    input [NB-1:0] v;
    integer k;
    begin
      popcnt = {CW{1'b0}};
      for (k = 0; k < NB; k = k + 1) begin
        popcnt = popcnt + {{(CW-1){1'b0}}, v[k]};
      end
    end
  endfunction

  reg [NB-1:0] blk;
  reg          ok;
  integer      i;

  // ==========================================
  // Tolerance check
  always @* begin
    blk = ~hit_i;
    ok  = ~blk[0];
    if (!rres_i) begin
      ok = ok & ~(|blk);
    end else begin
      // A run of three blocked beams exceeds the two-beam tolerance
      for (i = 1; i < NB - 2; i = i + 1) begin
        if (blk[i] & blk[i+1] & blk[i+2]) begin
          ok = 1'b0;
        end
      end
    end
  end

  always @(posedge mclk_i) begin
    if (rst_i) begin
      clear_o   <= 1'b0;
      blocked_o <= {CW{1'b0}};
    end else begin
      clear_o   <= ok;
      blocked_o <= popcnt(blk);
    end
  end

endmodule // lcsc_chan

// ---- verilog/lcsc_defines.vh ----
// Constants for the light curtain safety controller: offsets, fields, resets, timing
`ifndef LCSC_DEFINES_VH
`define LCSC_DEFINES_VH

// ==========================================
// Clock and timing
`define LCSC_CLK_KHZ        200000
`define LCSC_RST_MIN_MS     250
`define LCSC_RST_MAX_MS     2000
`define LCSC_FB_SETTLE_MS   100
`define LCSC_BLINK_MS       250
`define LCSC_SELFTEST_CYC   8'h10

// ==========================================
// Register offsets
`define LCSC_OFF_CTRL       8'h00
`define LCSC_OFF_BLANK      8'h04
`define LCSC_OFF_STATUS     8'h08
`define LCSC_OFF_BEAMS      8'h0c

// ==========================================
// Control fields and reset values
`define LCSC_CTRL_LATCH     0
`define LCSC_CTRL_FBM_LO    1
`define LCSC_CTRL_FBM_HI    2
`define LCSC_CTRL_RRES      3
`define LCSC_CTRL_SCAN      4
`define LCSC_CTRL_RST       5'h00
`define LCSC_BLANK_RST      8'h00

// ==========================================
// Feedback modes and fault codes
`define LCSC_FBM_NONE       2'h0
`define LCSC_FBM_ONE        2'h1
`define LCSC_FBM_TWO        2'h2
`define LCSC_FLT_NONE       4'h0
`define LCSC_FLT_CHAN       4'h1
`define LCSC_FLT_FDBK       4'h2
`define LCSC_FLT_SELF       4'h3
`define LCSC_FLT_CFG        4'h4
`define LCSC_DISP_ERR       4'he

`endif

// ---- verilog/lcsc_top.v ----
// Light curtain safety controller: state machine, feedback check, indicators, APB
`timescale 1ns/100ps
`include "lcsc_defines.vh"

module lcsc_top #(
  parameter integer NB          = 20,
  parameter integer ZB          = 5,
  parameter integer CW          = 8,
  parameter integer RST_MIN_CYC = `LCSC_RST_MIN_MS * `LCSC_CLK_KHZ,
  parameter integer RST_MAX_CYC = `LCSC_RST_MAX_MS * `LCSC_CLK_KHZ,
  parameter integer FB_CYC      = `LCSC_FB_SETTLE_MS * `LCSC_CLK_KHZ,
  parameter integer BLINK_CYC   = `LCSC_BLINK_MS * `LCSC_CLK_KHZ
) (
  input  wire             mclk_i,
  input  wire             rst_i,
  input  wire             psel_i,
  input  wire             penable_i,
  input  wire             pwrite_i,
  input  wire [7:0]       paddr_i,
  input  wire [31:0]      pwdata_i,
  output reg  [31:0]      prdata_o,
  output reg              pready_o,
  output reg              pslverr_o,
  input  wire [NB-1:0]    beam_hit_i,
  input  wire             rx_code_i,
  input  wire             test_closed_i,
  input  wire             reset_sw_i,
  input  wire             fb1_i,
  input  wire             fb2_i,
  input  wire             selfchk_fault_i,
  output reg              emit_on_o,
  output reg              safety_switch_outputs_a_o,
  output reg              safety_switch_outputs_b_o,
  output reg              aux_o,
  output reg              status_grn_o,
  output reg              status_red_o,
  output reg              reset_yel_o,
  output reg  [NB/ZB-1:0] zone_grn_o,
  output reg  [NB/ZB-1:0] zone_red_o,
  output reg  [11:0]      disp_o,
  output reg              emit_grn_o,
  output reg              emit_red_o,
  output reg  [3:0]       emit_digit_o
);

  localparam integer NZ = NB / ZB;
  localparam [4:0] ST_INIT = 5'h01;
  localparam [4:0] ST_WAIT = 5'h02;
  localparam [4:0] ST_RUN  = 5'h04;
  localparam [4:0] ST_BLK  = 5'h08;
  localparam [4:0] ST_LOCK = 5'h10;

  // ==========================================
  // Pin synchronisers; channel B has its own copy of the beams
  reg [NB+5:0] pin_s1_reg;
  reg [NB+5:0] pin_s2_reg;
  reg [NB-1:0] beam_b1_reg;
  reg [NB-1:0] beam_b2_reg;

  always @(posedge mclk_i) begin
    if (rst_i) begin
      pin_s1_reg  <= {(NB+6){1'b0}};
      pin_s2_reg  <= {(NB+6){1'b0}};
      beam_b1_reg <= {NB{1'b0}};
      beam_b2_reg <= {NB{1'b0}};
    end else begin
      pin_s1_reg  <= {selfchk_fault_i, fb2_i, fb1_i, reset_sw_i, test_closed_i,
                      rx_code_i, beam_hit_i};
      pin_s2_reg  <= pin_s1_reg;
      beam_b1_reg <= beam_hit_i;
      beam_b2_reg <= beam_b1_reg;
    end
  end

  wire [NB-1:0] beam_s   = pin_s2_reg[NB-1:0];
  wire          code_s   = pin_s2_reg[NB];
  wire          test_s   = pin_s2_reg[NB+1];
  wire          rsw_s    = pin_s2_reg[NB+2];
  wire          fb1_s    = pin_s2_reg[NB+3];
  wire          fb2_s    = pin_s2_reg[NB+4];
  wire          selflt_s = pin_s2_reg[NB+5];

  // ==========================================
  // Configuration registers
  reg [4:0]  ctrl_reg;
  reg [7:0]  blank_reg;
  wire       latch_mode = ctrl_reg[`LCSC_CTRL_LATCH];
  wire [1:0] fbm_mode   = ctrl_reg[`LCSC_CTRL_FBM_HI:`LCSC_CTRL_FBM_LO];
  wire       rres       = ctrl_reg[`LCSC_CTRL_RRES];
  wire       scan_code  = ctrl_reg[`LCSC_CTRL_SCAN];

  // Beams count only while emitting with a matching scan code
  wire          light_ok = test_s & (code_s == scan_code);
  wire [NB-1:0] hit_a    = beam_s & {NB{light_ok}};
  wire [NB-1:0] hit_b    = beam_b2_reg & {NB{light_ok}};

  // ==========================================
  // Redundant channels
  wire          clear_a;
  wire          clear_b;
  wire [CW-1:0] blocked_a;
  wire [CW-1:0] blocked_b;

  lcsc_chan #(.NB(NB), .CW(CW)) u_chan_a (
    .mclk_i    (mclk_i),
    .rst_i     (rst_i),
    .hit_i     (hit_a),
    .rres_i    (rres),
    .clear_o   (clear_a),
    .blocked_o (blocked_a)
  );

  lcsc_chan #(.NB(NB), .CW(CW)) u_chan_b (
    .mclk_i    (mclk_i),
    .rst_i     (rst_i),
    .hit_i     (hit_b),
    .rres_i    (rres),
    .clear_o   (clear_b),
    .blocked_o (blocked_b)
  );

  // Disagreement on two cycles in a row, beyond the sync skew, is a failed part
  reg  mis_prev_reg;
  wire mis_now  = (clear_a != clear_b) | (blocked_a != blocked_b);
  wire chan_flt = mis_now & mis_prev_reg;

  // ==========================================
  // Monitored manual reset
  reg [31:0] rsw_cnt_reg;
  reg        rsw_prev_reg;
  reg        rst_ok_reg;

  always @(posedge mclk_i) begin
    if (rst_i) begin
      rsw_cnt_reg  <= 32'h0;
      rsw_prev_reg <= 1'b0;
      rst_ok_reg   <= 1'b0;
    end else begin
      rsw_prev_reg <= rsw_s;
      if (!rsw_s) begin
        rsw_cnt_reg <= 32'h0;
      end else if (rsw_cnt_reg <= RST_MAX_CYC) begin
        rsw_cnt_reg <= rsw_cnt_reg + 32'h1;
      end
      // A tied-down button never opens, so it never produces a reset
      rst_ok_reg <= rsw_prev_reg & ~rsw_s & (rsw_cnt_reg >= RST_MIN_CYC)
                    & (rsw_cnt_reg <= RST_MAX_CYC);
    end
  end

  // ==========================================
  // Contactor feedback monitor
  reg [31:0] fb_cnt_reg;
  reg        out_on_reg;
  wire       fb_exp = ~out_on_reg;
  reg        fb_err;

  always @* begin
    case (fbm_mode)
      `LCSC_FBM_ONE: fb_err = (fb1_s != fb_exp);
      `LCSC_FBM_TWO: fb_err = (fb1_s != fb_exp) | (fb2_s != fb_exp);
      default:       fb_err = 1'b0;
    endcase
  end

  always @(posedge mclk_i) begin
    if (rst_i) begin
      fb_cnt_reg <= 32'h0;
    end else if (!fb_err) begin
      fb_cnt_reg <= 32'h0;
    end else if (fb_cnt_reg < FB_CYC) begin
      fb_cnt_reg <= fb_cnt_reg + 32'h1;
    end
  end

  wire fb_flt  = (fb_cnt_reg >= FB_CYC);
  wire cfg_flt = (fbm_mode == 2'h3);
  wire any_flt = chan_flt | fb_flt | selflt_s | cfg_flt;

  // ==========================================
  // Operating state machine
  reg [4:0] st_reg;
  reg [4:0] st_next;
  reg [7:0] tst_cnt_reg;
  reg [3:0] flt_reg;

  always @* begin
    st_next = st_reg;
    case (st_reg)
      ST_INIT: begin
        if ((tst_cnt_reg == `LCSC_SELFTEST_CYC) && clear_a && hit_a[0]) begin
          st_next = latch_mode ? ST_WAIT : ST_RUN;
        end
      end
      ST_WAIT: begin
        if (rst_ok_reg && clear_a) begin
          st_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!clear_a) begin
          st_next = latch_mode ? ST_WAIT : ST_BLK;
        end
      end
      ST_BLK: begin
        if (clear_a) begin
          st_next = ST_RUN;
        end
      end
      ST_LOCK: begin
        if (rst_ok_reg && !any_flt) begin
          st_next = ST_INIT;
        end
      end
      default: st_next = ST_LOCK;
    endcase
    if (any_flt) begin
      st_next = ST_LOCK;
    end
  end

  always @(posedge mclk_i) begin
    if (rst_i) begin
      st_reg       <= ST_INIT;
      tst_cnt_reg  <= 8'h00;
      flt_reg      <= `LCSC_FLT_NONE;
      mis_prev_reg <= 1'b0;
      out_on_reg   <= 1'b0;
    end else begin
      st_reg       <= st_next;
      mis_prev_reg <= mis_now;
      out_on_reg   <= (st_next == ST_RUN);
      if (st_reg != ST_INIT) begin
        tst_cnt_reg <= 8'h00;
      end else if (tst_cnt_reg != `LCSC_SELFTEST_CYC) begin
        tst_cnt_reg <= tst_cnt_reg + 8'h01;
      end
      // First cause is kept until the lockout is left
      if (st_reg != ST_LOCK && any_flt) begin
        flt_reg <= chan_flt ? `LCSC_FLT_CHAN : fb_flt ? `LCSC_FLT_FDBK :
                   selflt_s ? `LCSC_FLT_SELF : `LCSC_FLT_CFG;
      end else if (st_reg == ST_LOCK && st_next == ST_INIT) begin
        flt_reg <= `LCSC_FLT_NONE;
      end
    end
  end

  // ==========================================
  // Flash timing
  reg [31:0] blink_cnt_reg;
  reg        blink_reg;

  always @(posedge mclk_i) begin
    if (rst_i) begin
      blink_cnt_reg <= 32'h0;
      blink_reg     <= 1'b0;
    end else if (blink_cnt_reg >= BLINK_CYC - 1) begin
      blink_cnt_reg <= 32'h0;
      blink_reg     <= ~blink_reg;
    end else begin
      blink_cnt_reg <= blink_cnt_reg + 32'h1;
    end
  end

  // ==========================================
  // Indicator next values
  wire lock = (st_reg == ST_LOCK);
  reg [NZ-1:0] zgrn_next;
  reg [NZ-1:0] zred_next;
  integer z;

  always @* begin
    for (z = 0; z < NZ; z = z + 1) begin
      zgrn_next[z] = blank_reg[z] ? blink_reg : (&hit_a[z*ZB +: ZB]);
      zred_next[z] = ~blank_reg[z] & ~(&hit_a[z*ZB +: ZB]);
    end
  end

  // ==========================================
  // Registered outputs
  always @(posedge mclk_i) begin
    if (rst_i) begin
      emit_on_o                 <= 1'b0;
      safety_switch_outputs_a_o <= 1'b0;
      safety_switch_outputs_b_o <= 1'b0;
      aux_o                     <= 1'b0;
      status_grn_o              <= 1'b0;
      status_red_o              <= 1'b0;
      reset_yel_o               <= 1'b0;
      zone_grn_o                <= {NZ{1'b0}};
      zone_red_o                <= {NZ{1'b0}};
      disp_o                    <= 12'h000;
      emit_grn_o                <= 1'b0;
      emit_red_o                <= 1'b0;
      emit_digit_o              <= 4'h0;
    end else begin
      emit_on_o                 <= test_s;
      safety_switch_outputs_a_o <= out_on_reg & ~any_flt;
      safety_switch_outputs_b_o <= out_on_reg & ~any_flt;
      // Safety output terms gated by feedback mode one, so a fault drops aux in the same cycle
      aux_o        <= out_on_reg & ~any_flt & (fbm_mode == `LCSC_FBM_ONE);
      status_grn_o <= ~lock & out_on_reg & (~rres | blink_reg);
      status_red_o <= lock ? blink_reg : ~out_on_reg;
      reset_yel_o  <= (st_reg == ST_RUN) | (st_reg == ST_BLK) |
                      (((st_reg == ST_WAIT) | lock) & blink_reg);
      zone_grn_o   <= zgrn_next;
      zone_red_o   <= zred_next;
      disp_o       <= lock ? {`LCSC_DISP_ERR, 4'h0, flt_reg} :
                             {{(12-CW){1'b0}}, blocked_a};
      // Emitter: red steady at power-up, green in run, flashing green in test
      emit_grn_o   <= ~lock & (st_reg != ST_INIT) & (test_s | blink_reg);
      emit_red_o   <= lock ? blink_reg : (st_reg == ST_INIT);
      emit_digit_o <= lock ? flt_reg : {3'h0, scan_code} + 4'h1;
    end
  end

  // ==========================================
  // APB slave, no wait states, unmapped addresses answer with pslverr
  wire setup  = psel_i & ~penable_i & ~pready_o;
  wire access = psel_i & penable_i & pready_o;
  wire mapped = (paddr_i == `LCSC_OFF_CTRL) | (paddr_i == `LCSC_OFF_BLANK) |
                (paddr_i == `LCSC_OFF_STATUS) | (paddr_i == `LCSC_OFF_BEAMS);
  reg [31:0] rd_next;

  always @* begin
    case (paddr_i)
      `LCSC_OFF_CTRL:   rd_next = {27'h0, ctrl_reg};
      `LCSC_OFF_BLANK:  rd_next = {24'h0, blank_reg};
      `LCSC_OFF_STATUS: rd_next = {16'h0, blocked_a, flt_reg, lock, st_reg == ST_RUN,
                                   st_reg == ST_WAIT, out_on_reg};
      `LCSC_OFF_BEAMS:  rd_next = {{(32-NB){1'b0}}, ~hit_a};
      default:          rd_next = 32'h0;
    endcase
  end

  always @(posedge mclk_i) begin
    if (rst_i) begin
      prdata_o  <= 32'h0;
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      ctrl_reg  <= `LCSC_CTRL_RST;
      blank_reg <= `LCSC_BLANK_RST;
    end else begin
      pready_o  <= setup;
      pslverr_o <= setup & ~mapped;
      if (setup) begin
        prdata_o <= pwrite_i ? 32'h0 : rd_next;
      end
      if (access && pwrite_i && paddr_i == `LCSC_OFF_CTRL) begin
        ctrl_reg <= pwdata_i[4:0];
      end
      if (access && pwrite_i && paddr_i == `LCSC_OFF_BLANK) begin
        blank_reg <= pwdata_i[7:0];
      end
    end
  end

endmodule // lcsc_top
